// File: rtl/cmp_ctrl_pkg.sv
package cmp_ctrl_pkg;

  // Register byte offsets
  localparam logic [7:0] OFS_GLOBAL_CFG  = 8'h00;
  localparam logic [7:0] OFS_IRQ_FLAGS   = 8'h04;
  localparam logic [7:0] OFS_IRQ_SET     = 8'h08;
  localparam logic [7:0] OFS_IRQ_GATE    = 8'h0c;
  localparam logic [7:0] OFS_IRQ_GATED   = 8'h10;
  localparam logic [7:0] OFS_STATUS      = 8'h14;
  localparam logic [7:0] OFS_CTRL_A      = 8'h18;
  localparam logic [7:0] OFS_CTRL_B      = 8'h1c;

  // Field positions
  localparam int POS_LIVE_A     = 0;
  localparam int POS_LIVE_B     = 16;
  localparam int POS_FLAG_A     = 0;
  localparam int POS_FLAG_B     = 1;
  localparam int POS_GLOBAL_EN  = 31;
  localparam int POS_PWR_LO     = 0;
  localparam int POS_HYST       = 5;
  localparam int POS_EDGE_LO    = 6;

  // Reset values
  localparam logic [7:0] RST_CTRL       = 8'h00;
  localparam logic       RST_GLOBAL_EN  = 1'b0;
  localparam logic [1:0] RST_GATE       = 2'h0;

  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    EDGE_NONE    = 2'h0,
    EDGE_RISING  = 2'h1,
    EDGE_FALLING = 2'h2,
    EDGE_BOTH    = 2'h3
  } edge_sel_e;

  typedef enum logic [1:0] {
    PWR_OFF   = 2'h0,
    PWR_ULP   = 2'h1,
    PWR_LP    = 2'h2,
    PWR_FULL  = 2'h3
  } power_level_e;

  typedef struct packed {
    edge_sel_e    edge_sel;
    logic         hyst_on;
    power_level_e power_level;
  } cmp_ctrl_s;

  typedef struct packed {
    logic [1:0]    enable;
    logic [1:0]    hysteresis_on;
    logic [3:0]    power_level;
  } analog_ctrl_s;

endpackage

// File: rtl/dual_comparator_irq_control.sv
`timescale 1ns/1ps
`default_nettype none

module dual_comparator_irq_control
  import cmp_ctrl_pkg::*;
(
  input  wire logic         clock,
  input  wire logic         rst,
  input  wire logic [7:0]   s_axi_awaddr,
  input  wire logic         s_axi_awvalid,
  output logic              s_axi_awready,
  input  wire logic [31:0]  s_axi_wdata,
  input  wire logic [3:0]   s_axi_wstrb,
  input  wire logic         s_axi_wvalid,
  output logic              s_axi_wready,
  output logic [1:0]        s_axi_bresp,
  output logic              s_axi_bvalid,
  input  wire logic         s_axi_bready,
  input  wire logic [7:0]   s_axi_araddr,
  input  wire logic         s_axi_arvalid,
  output logic              s_axi_arready,
  output logic [31:0]       s_axi_rdata,
  output logic [1:0]        s_axi_rresp,
  output logic              s_axi_rvalid,
  input  wire logic         s_axi_rready,
  input  wire logic [1:0]   cmp_raw_output,
  input  wire logic         deep_sleep_mode,
  input  wire logic         hibernate_mode,
  output analog_ctrl_s      analog_ctrl,
  output logic [1:0]        cmp_pin_output,
  output logic              irq,
  output logic              wakeup_irq_unit_req,
  output logic              resources_wake_req
);

  typedef struct packed {
    logic [1:0]  sync1;
    logic [1:0]  sync2;
    logic [1:0]  prev;
    logic [1:0]  slp1;
    logic [1:0]  slp2;
    cmp_ctrl_s   ctrl_a;
    cmp_ctrl_s   ctrl_b;
    logic        global_en;
    logic [1:0]  flags;
    logic [1:0]  gate;
    logic        aw_held;
    logic [7:0]  aw_addr;
    logic        w_held;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic        wake_dsl;
    logic        wake_hib;
  } state_s;

  // Control reset value split into its fields
  localparam cmp_ctrl_s CTRL_RST = '{
    edge_sel:    edge_sel_e'(RST_CTRL[POS_EDGE_LO +: 2]),
    hyst_on:     RST_CTRL[POS_HYST],
    power_level: power_level_e'(RST_CTRL[POS_PWR_LO +: 2])
  };

  localparam state_s STATE_RST = '{
    sync1:     2'h0,
    sync2:     2'h0,
    prev:      2'h0,
    slp1:      2'h0,
    slp2:      2'h0,
    ctrl_a:    CTRL_RST,
    ctrl_b:    CTRL_RST,
    global_en: RST_GLOBAL_EN,
    flags:     2'h0,
    gate:      RST_GATE,
    aw_held:   1'b0,
    aw_addr:   8'h00,
    w_held:    1'b0,
    w_data:    32'h0,
    w_strb:    4'h0,
    bvalid:    1'b0,
    bresp:     2'h0,
    rvalid:    1'b0,
    rdata:     32'h0,
    rresp:     2'h0,
    wake_dsl:  1'b0,
    wake_hib:  1'b0
  };

  state_s     st_ff;
  state_s     nxt_st;
  logic [1:0] edge_hit;
  logic [1:0] live;
  logic [1:0] comp_on;
  logic [1:0] irq_pend;
  edge_sel_e  sel [2];

  function automatic logic [7:0] ctrl_word(input cmp_ctrl_s c);
    logic [7:0] w;
    w = 8'h00;
    w[POS_EDGE_LO +: 2] = c.edge_sel;
    w[POS_HYST] = c.hyst_on;
    w[POS_PWR_LO +: 2] = c.power_level;
    return w;
  endfunction

  function automatic cmp_ctrl_s ctrl_from(input logic [7:0] w);
    cmp_ctrl_s c;
    c.edge_sel = edge_sel_e'(w[POS_EDGE_LO +: 2]);
    c.hyst_on = w[POS_HYST];
    c.power_level = power_level_e'(w[POS_PWR_LO +: 2]);
    return c;
  endfunction

  assign sel[0] = st_ff.ctrl_a.edge_sel;
  assign sel[1] = st_ff.ctrl_b.edge_sel;
  assign live = st_ff.sync2;

  // Per-comparator enable and edge detection
  for (genvar i = 0; i < 2; i++) begin : g_cmp
    power_level_e pl;
    logic         rise;
    logic         fall;
    assign pl = (i == 0) ? st_ff.ctrl_a.power_level
                         : st_ff.ctrl_b.power_level;
    assign comp_on[i] = st_ff.global_en && (pl != PWR_OFF);
    // Edges from synced value against its previous sample
    assign rise = live[i] && !st_ff.prev[i];
    assign fall = !live[i] && st_ff.prev[i];
    always_comb begin
      case (sel[i])
        EDGE_RISING: begin
          edge_hit[i] = rise;
        end
        EDGE_FALLING: begin
          edge_hit[i] = fall;
        end
        EDGE_BOTH: begin
          edge_hit[i] = rise || fall;
        end
        default: begin
          edge_hit[i] = 1'b0;
        end
      endcase
    end
    assign irq_pend[i] = st_ff.flags[i] && st_ff.gate[i];
  end

  always_comb begin
    analog_ctrl.enable = comp_on;
    analog_ctrl.hysteresis_on = {st_ff.ctrl_b.hyst_on,
                                 st_ff.ctrl_a.hyst_on};
    analog_ctrl.power_level = {st_ff.ctrl_b.power_level,
                               st_ff.ctrl_a.power_level};
  end

  assign cmp_pin_output = st_ff.sync2;
  assign irq = |irq_pend;
  assign wakeup_irq_unit_req = st_ff.wake_dsl;
  assign resources_wake_req = st_ff.wake_hib;

  assign s_axi_awready = !st_ff.aw_held && !st_ff.bvalid;
  assign s_axi_wready  = !st_ff.w_held && !st_ff.bvalid;
  assign s_axi_bvalid  = st_ff.bvalid;
  assign s_axi_bresp   = st_ff.bresp;
  assign s_axi_arready = !st_ff.rvalid;
  assign s_axi_rvalid  = st_ff.rvalid;
  assign s_axi_rdata   = st_ff.rdata;
  assign s_axi_rresp   = st_ff.rresp;

  always_comb begin
    logic        do_wr;
    logic [7:0]  wa;
    logic [31:0] wd;
    logic [3:0]  ws;
    logic [1:0]  clr;
    logic [1:0]  set;
    logic [31:0] rd;
    logic        hit;
    logic [1:0]  hw_set;
    do_wr = 1'b0;
    wa = 8'h00;
    wd = 32'h0;
    ws = 4'h0;
    clr = 2'h0;
    set = 2'h0;
    rd = 32'h0;
    hit = 1'b1;
    hw_set = 2'h0;
    nxt_st = st_ff;
    // Two-flop input synchroniser
    nxt_st.sync1 = cmp_raw_output;
    nxt_st.sync2 = st_ff.sync1;
    nxt_st.prev = st_ff.sync2;
    nxt_st.slp1 = {hibernate_mode, deep_sleep_mode};
    nxt_st.slp2 = st_ff.slp1;
    // Write address and data, either order
    if (s_axi_awvalid && s_axi_awready) begin
      nxt_st.aw_held = 1'b1;
      nxt_st.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      nxt_st.w_held = 1'b1;
      nxt_st.w_data = s_axi_wdata;
      nxt_st.w_strb = s_axi_wstrb;
    end
    if (nxt_st.aw_held && nxt_st.w_held) begin
      do_wr = 1'b1;
      wa = nxt_st.aw_addr;
      wd = nxt_st.w_data;
      ws = nxt_st.w_strb;
      nxt_st.aw_held = 1'b0;
      nxt_st.w_held = 1'b0;
      nxt_st.bvalid = 1'b1;
      nxt_st.bresp = RESP_OKAY;
    end
    // Register write decode
    if (do_wr) begin
      case ({wa[7:2], 2'b00})
        OFS_GLOBAL_CFG: begin
          if (ws[3]) begin
            nxt_st.global_en = wd[POS_GLOBAL_EN];
          end
        end
        OFS_IRQ_FLAGS: begin
          if (ws[0]) begin
            clr = wd[POS_FLAG_A +: 2];
          end
        end
        OFS_IRQ_SET: begin
          if (ws[0]) begin
            set = wd[POS_FLAG_A +: 2];
          end
        end
        OFS_IRQ_GATE: begin
          if (ws[0]) begin
            nxt_st.gate = wd[POS_FLAG_A +: 2];
          end
        end
        OFS_CTRL_A: begin
          if (ws[0]) begin
            nxt_st.ctrl_a = ctrl_from(wd[7:0]);
          end
        end
        OFS_CTRL_B: begin
          if (ws[0]) begin
            nxt_st.ctrl_b = ctrl_from(wd[7:0]);
          end
        end
        OFS_IRQ_GATED, OFS_STATUS: begin
          // Read-only, a write has no effect
        end
        default: begin
          nxt_st.bresp = RESP_SLVERR;
        end
      endcase
    end
    if (st_ff.bvalid && s_axi_bready) begin
      nxt_st.bvalid = 1'b0;
    end
    // Flags: set wins over clear, held until cleared
    hw_set = edge_hit & comp_on;
    nxt_st.flags = (st_ff.flags & ~clr) | set | hw_set;
    nxt_st.wake_dsl = st_ff.slp2[0] && |(hw_set & st_ff.gate);
    nxt_st.wake_hib = st_ff.slp2[1] && |(hw_set & st_ff.gate);
    // Read channel
    if (s_axi_arvalid && s_axi_arready) begin
      case ({s_axi_araddr[7:2], 2'b00})
        OFS_GLOBAL_CFG: begin
          rd[POS_GLOBAL_EN] = st_ff.global_en;
        end
        OFS_IRQ_FLAGS: begin
          rd[POS_FLAG_A +: 2] = st_ff.flags;
        end
        OFS_IRQ_SET: begin
          rd[POS_FLAG_A +: 2] = st_ff.flags;
        end
        OFS_IRQ_GATE: begin
          rd[POS_FLAG_A +: 2] = st_ff.gate;
        end
        OFS_IRQ_GATED: begin
          rd[POS_FLAG_A +: 2] = irq_pend;
        end
        OFS_STATUS: begin
          rd[POS_LIVE_A] = live[0];
          rd[POS_LIVE_B] = live[1];
        end
        OFS_CTRL_A: begin
          rd[7:0] = ctrl_word(st_ff.ctrl_a);
        end
        OFS_CTRL_B: begin
          rd[7:0] = ctrl_word(st_ff.ctrl_b);
        end
        default: begin
          hit = 1'b0;
        end
      endcase
      nxt_st.rvalid = 1'b1;
      nxt_st.rdata = rd;
      if (hit) begin
        nxt_st.rresp = RESP_OKAY;
      end else begin
        nxt_st.rresp = RESP_SLVERR;
      end
    end else if (st_ff.rvalid && s_axi_rready) begin
      nxt_st.rvalid = 1'b0;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      st_ff <= STATE_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

endmodule

`default_nettype wire

// File: testbench/cmp_core_model.sv
`timescale 1ns/1ps
`default_nettype none
module cmp_core_model
  import cmp_ctrl_pkg::*;
(
  input  wire logic       clock,
  input  wire logic [1:0] level,
  output logic [1:0]      raw
);
  // Analog response lands one clock after the input moves
  always_ff @(posedge clock) begin
    raw <= level;
  end
endmodule
`default_nettype wire

// File: testbench/cmp_ctrl_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module cmp_ctrl_assertions
  import cmp_ctrl_pkg::*;
(
  input wire logic         clock,
  input wire logic         rst,
  input wire logic         s_axi_awvalid,
  input wire logic         s_axi_awready,
  input wire logic         s_axi_wvalid,
  input wire logic         s_axi_wready,
  input wire logic         s_axi_bvalid,
  input wire logic         s_axi_bready,
  input wire logic         s_axi_arvalid,
  input wire logic         s_axi_arready,
  input wire logic         s_axi_rvalid,
  input wire logic         s_axi_rready,
  input wire logic [1:0]   cmp_raw_output,
  input wire logic [1:0]   cmp_pin_output,
  input wire logic         irq,
  input wire logic         wakeup_irq_unit_req,
  input wire logic         resources_wake_req,
  input wire analog_ctrl_s analog_ctrl
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  chk_b_answer: assert property (s_axi_awvalid && s_axi_awready &&
    s_axi_wvalid && s_axi_wready |=> s_axi_bvalid) else $error("no bvalid");
  chk_r_answer: assert property (s_axi_arvalid && s_axi_arready
    |=> s_axi_rvalid) else $error("no rvalid");
  chk_b_done: assert property (s_axi_bvalid && s_axi_bready
    |=> !s_axi_bvalid) else $error("bvalid stuck");
  chk_r_done: assert property (s_axi_rvalid && s_axi_rready
    |=> !s_axi_rvalid) else $error("rvalid stuck");
  chk_pin_follows: assert property ($stable(cmp_raw_output)[*5]
    |-> cmp_pin_output == cmp_raw_output) else $error("pin wrong");
  chk_wake_pulse: assert property (wakeup_irq_unit_req ||
    resources_wake_req |=> !(wakeup_irq_unit_req || resources_wake_req))
    else $error("wake not a pulse");
  chk_power_enable: assert property (analog_ctrl.enable[0]
    |-> analog_ctrl.power_level[1:0] != PWR_OFF) else $error("bad enable");
  chk_irq_sticky: assert property ($fell(irq) |->
    $past(s_axi_wvalid && s_axi_wready) ||
    $past(s_axi_wvalid && s_axi_wready, 2)) else $error("irq dropped");
  cover property (irq);
  cover property (wakeup_irq_unit_req);
  cover property (resources_wake_req);
endmodule
bind dual_comparator_irq_control cmp_ctrl_assertions cmp_ctrl_assertions_i (.*);
`default_nettype wire

// File: testbench/dual_comparator_irq_control_test.sv
`timescale 1ns/1ps
`default_nettype none
`define CK(n, e, a) begin compares++; if ((a) !== (e)) begin \
  error_cnt++; $display("unexpected %s exp %0h got %0h", n, e, a); end end
module dual_comparator_irq_control_test import cmp_ctrl_pkg::*;;
  logic         clock = 0, rst = 1;
  logic [7:0]   aa = 0, ra = 0;
  logic [31:0]  wd = 0, rdata, rd_d;
  logic         av = 0, wv = 0, br = 0, rv = 0, rr = 0, ds = 0, hb = 0;
  logic [1:0]   lv = 0, raw, pin, rsp, bresp, rresp;
  logic         aw_rdy, w_rdy, bv, ar_rdy, rvl, irq, wk, rs;
  analog_ctrl_s ac;
  int           error_cnt = 0, compares = 0, cyc = 0;
  dual_comparator_irq_control dual_comparator_irq_control_i (
    .clock(clock), .rst(rst), .s_axi_awaddr(aa), .s_axi_awvalid(av),
    .s_axi_awready(aw_rdy), .s_axi_wdata(wd), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(wv), .s_axi_wready(w_rdy), .s_axi_bresp(bresp),
    .s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_araddr(ra),
    .s_axi_arvalid(rv), .s_axi_arready(ar_rdy), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvl), .s_axi_rready(rr),
    .cmp_raw_output(raw), .deep_sleep_mode(ds), .hibernate_mode(hb),
    .analog_ctrl(ac), .cmp_pin_output(pin), .irq(irq),
    .wakeup_irq_unit_req(wk), .resources_wake_req(rs));
  cmp_core_model cmp_core_model_i (.clock(clock), .level(lv), .raw(raw));
  always #20 clock = ~clock;
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 8000) begin
      error_cnt++;
      wrap_up();
    end
  end
  task automatic wrap_up();
    $display("compares %0d error_cnt %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic w(input int n);
    repeat (n) @(posedge clock);
  endtask
  // One bus transfer: write when wr is set, else read into rd_d
  task automatic io(input bit wr, input logic [7:0] a, input logic [31:0] d);
    bit b;
    b = 0;
    @(posedge clock);
    if (wr) begin
      aa <= a;
      wd <= d;
      {av, wv, br} <= 3'h7;
    end else begin
      ra <= a;
      {rv, rr} <= 2'h3;
    end
    while (!b) begin
      @(posedge clock);
      if (aw_rdy) av <= 0;
      if (w_rdy) wv <= 0;
      if (ar_rdy) rv <= 0;
      if (bv || rvl) begin
        rsp = wr ? bresp : rresp;
        rd_d = rdata;
        {br, rr} <= 2'h0;
        b = 1;
      end
    end
  endtask
  task automatic t_reset();
    for (int i = 0; i < 8; i++) begin
      io(0, 8'(4 * i), 0);
      `CK("reg", 32'h0, rd_d)
    end
    `CK("ac", 8'h0, ac)
    io(0, 8'h40, 0);
    `CK("rresp", RESP_SLVERR, rsp)
    io(1, 8'h40, 32'h3);
    `CK("bresp", RESP_SLVERR, rsp)
    $display("reset test done");
  endtask
  task automatic t_status();
    for (int k = 0; k < 2; k++) begin
      lv <= 2'(1 << k);
      w(6);
      io(0, OFS_STATUS, 0);
      `CK("status", 32'h1 << (16 * k), rd_d)
      `CK("pin", 2'(1 << k), pin)
    end
    lv <= 2'h0;
    w(6);
    $display("status test done");
  endtask
  task automatic t_edges();
    io(1, OFS_GLOBAL_CFG, 32'h8000_0000);
    for (int c = 0; c < 2; c++) begin
      for (int s = 0; s < 4; s++) begin
        io(1, c ? OFS_CTRL_B : OFS_CTRL_A, 32'(s << 6) | 32'h3);
        io(1, OFS_IRQ_FLAGS, 32'h3);
        lv[c] <= 1;
        w(6);
        io(0, OFS_IRQ_FLAGS, 0);
        `CK("rise", 32'(s & 1) << c, rd_d)
        lv[c] <= 0;
        w(6);
        io(0, OFS_IRQ_FLAGS, 0);
        `CK("fall", 32'(s != 0) << c, rd_d)
      end
    end
    io(1, OFS_GLOBAL_CFG, 0);
    io(1, OFS_IRQ_FLAGS, 32'h3);
    lv <= 2'h3;
    w(6);
    lv <= 2'h0;
    w(6);
    io(0, OFS_IRQ_FLAGS, 0);
    `CK("off", 32'h0, rd_d)
    $display("edge test done");
  endtask
  task automatic t_irq();
    io(1, OFS_IRQ_SET, 32'h1);
    io(0, OFS_IRQ_FLAGS, 0);
    `CK("set", 32'h1, rd_d)
    `CK("irq", 1'b0, irq)
    io(1, OFS_IRQ_GATE, 32'h1);
    `CK("irq", 1'b1, irq)
    io(1, OFS_IRQ_FLAGS, 32'h2);
    `CK("irq", 1'b1, irq)
    io(1, OFS_IRQ_FLAGS, 32'h1);
    `CK("irq", 1'b0, irq)
    io(1, OFS_IRQ_SET, 32'h2);
    `CK("irq", 1'b0, irq)
    io(1, OFS_IRQ_GATE, 32'h3);
    io(0, OFS_IRQ_GATED, 0);
    `CK("gated", 32'h2, rd_d)
    `CK("irq", 1'b1, irq)
    io(1, OFS_IRQ_FLAGS, 32'h3);
    $display("irq test done");
  endtask
  task automatic t_power();
    for (int p = 0; p < 4; p++) begin
      io(1, OFS_GLOBAL_CFG, 0);
      io(1, OFS_CTRL_A, 32'h20 | 32'(p));
      `CK("en", 1'b0, ac.enable[0])
      io(1, OFS_GLOBAL_CFG, 32'h8000_0000);
      io(0, OFS_CTRL_A, 0);
      `CK("ctl", 32'h20 | 32'(p), rd_d)
      `CK("en", p != 0, ac.enable[0])
      `CK("pw", 2'(p), ac.power_level[1:0])
      `CK("hy", 1'b1, ac.hysteresis_on[0])
    end
    $display("power test done");
  endtask
  task automatic t_wake();
    int n1, n2;
    io(1, OFS_GLOBAL_CFG, 0);
    io(1, OFS_CTRL_A, 32'h41);
    io(1, OFS_IRQ_GATE, 32'h1);
    io(1, OFS_GLOBAL_CFG, 32'h8000_0000);
    for (int m = 0; m < 2; m++) begin
      {ds, hb} <= m ? 2'h1 : 2'h2;
      w(4);
      lv[0] <= 1;
      n1 = 0;
      n2 = 0;
      repeat (10) begin
        @(posedge clock);
        n1 += wk;
        n2 += rs;
      end
      lv[0] <= 0;
      `CK("sleep wake", 32'(m == 0), n1)
      `CK("hib wake", 32'(m), n2)
    end
    $display("wake test done");
  endtask
  initial begin
    w(16);
    rst <= 0;
    t_reset();
    t_status();
    t_edges();
    t_irq();
    t_power();
    t_wake();
    wrap_up();
  end
endmodule
`default_nettype wire
